// ==== hw/ems_cfg.svh ====
`ifndef EMS_CFG_SVH
`define EMS_CFG_SVH
`define EMS_CLK_NS 4
`define EMS_HALF_PERIOD_NS 8
`define EMS_HP_DIV (`EMS_HALF_PERIOD_NS / `EMS_CLK_NS)
`define EMS_REF_PERIOD_NS 200
`define EMS_REF_DIV (`EMS_REF_PERIOD_NS / `EMS_CLK_NS)
`define EMS_SCAN_LINES 32
`define EMS_SCAN_WINDOW 144
`define EMS_DEFAULT_LINE 5'h1f
`define EMS_DEFAULT_PRESET {3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 5'h1f, 5'h1e, 5'h1e, 5'h12, 1'b1, 7'h48}
`define EMS_OFF_CTRL 12'h000
`define EMS_OFF_ADDR 12'h004
`define EMS_OFF_WDATA 12'h008
`define EMS_OFF_STATUS 12'h00c
`define EMS_OFF_RDATA 12'h010
`define EMS_CTRL_GO 0
`define EMS_CTRL_WRITE 1
`define EMS_CTRL_INTERNAL 2
`define EMS_CTRL_BE_LSB 4
`define EMS_CTRL_WAIT_LSB 8
`define EMS_CTRL_HOLD_LSB 12
`endif

// ==== hw/ems_pkg.sv ====
package ems_pkg;
    typedef enum logic [3:0] {
        PH_IDLE, PH_T1, PH_T2, PH_T3, PH_T4, PH_WAIT, PH_T5, PH_T6, PH_E
    } ems_phase_t;
    typedef struct packed {
        logic [2:0] t1;
        logic [2:0] t2;
        logic [2:0] t3;
        logic [2:0] t4;
        logic [2:0] t5;
        logic [2:0] t6;
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] s4;
        logic late;
        logic [6:0] refresh;
    } ems_preset_t;
endpackage

// ==== hw/ems_write_strobe.sv ====
`timescale 1ns/1ps
`include "ems_cfg.svh"
module ems_write_strobe (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic config_sense_input,
    input wire logic [29:0] muxed_addr_data_bus_i,
    output logic [29:0] muxed_addr_data_bus_o,
    output logic [29:0] muxed_addr_data_bus_oe_n,
    input wire logic write_flag_data0_i,
    output logic write_flag_data0_o,
    output logic write_flag_data0_oe_n,
    input wire logic refresh_flag_data1_i,
    output logic refresh_flag_data1_o,
    output logic refresh_flag_data1_oe_n,
    output logic [3:0] byte_write_strobe_n,
    output logic address_strobe_n,
    output logic programmable_width_strobe_n,
    output logic [2:0] delayed_strobe_n,
    output logic processor_clock_output
);
    function automatic ems_pkg::ems_preset_t preset_f(input logic [4:0] line);
        ems_pkg::ems_preset_t p;
        p = `EMS_DEFAULT_PRESET;
        case (line)
            5'h00: p = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 5'h1e, 5'h01, 5'h03, 5'h05, 1'b1, 7'h48};
            5'h01: p = '{3'h1, 3'h2, 3'h1, 3'h1, 3'h1, 3'h2, 5'h1e, 5'h01, 5'h02, 5'h07, 1'b1, 7'h48};
            5'h02: p = '{3'h1, 3'h2, 3'h1, 3'h1, 3'h2, 3'h3, 5'h1e, 5'h01, 5'h02, 5'h07, 1'b1, 7'h48};
            5'h03: p = '{3'h2, 3'h3, 3'h1, 3'h1, 3'h2, 3'h3, 5'h1e, 5'h01, 5'h03, 5'h08, 1'b1, 7'h48};
            5'h04: p = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 5'h03, 5'h01, 5'h02, 5'h03, 1'b0, 7'h48};
            5'h05: p = '{3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 5'h05, 5'h01, 5'h02, 5'h03, 1'b0, 7'h48};
            5'h06: p = '{3'h2, 3'h1, 3'h2, 3'h1, 3'h3, 3'h1, 5'h06, 5'h01, 5'h02, 5'h03, 1'b0, 7'h48};
            5'h07: p = '{3'h2, 3'h2, 3'h2, 3'h1, 3'h3, 3'h2, 5'h07, 5'h01, 5'h03, 5'h04, 1'b0, 7'h48};
            5'h08: p = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 5'h1e, 5'h01, 5'h02, 5'h03, 1'b0, 7'h00};
            5'h09: p = '{3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 5'h1e, 5'h02, 5'h05, 5'h09, 1'b0, 7'h00};
            5'h0a: p = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h4, 3'h2, 5'h1e, 5'h02, 5'h03, 5'h08, 1'b1, 7'h48};
            5'h0b: p = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 5'h1e, 5'h02, 5'h04, 5'h0d, 1'b1, 7'h48};
            5'h0c: p = '{3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 5'h04, 5'h01, 5'h02, 5'h03, 1'b0, 7'h48};
            5'h0d: p = '{3'h2, 3'h1, 3'h2, 3'h1, 3'h2, 3'h2, 5'h05, 5'h01, 5'h02, 5'h03, 1'b0, 7'h48};
            5'h0e: p = '{3'h2, 3'h2, 3'h2, 3'h1, 3'h3, 3'h2, 5'h06, 5'h01, 5'h03, 5'h04, 1'b0, 7'h48};
            5'h0f: p = '{3'h2, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 5'h08, 5'h01, 5'h02, 5'h03, 1'b0, 7'h48};
            default: p = p;
        endcase
        return p;
    endfunction

    function automatic logic sel_f(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    // apb registers
    logic [31:0] ctrl_r;
    logic [29:0] addr_r;
    logic [31:0] wdata_r;
    logic [31:0] rdata_r;
    logic go_r;
    logic setup;
    logic wr_access;
    logic mapped;
    assign setup = psel & ~penable;
    assign wr_access = psel & penable & pwrite;
    assign mapped = sel_f(paddr, `EMS_OFF_CTRL) | sel_f(paddr, `EMS_OFF_ADDR) | sel_f(paddr, `EMS_OFF_WDATA)
        | sel_f(paddr, `EMS_OFF_STATUS) | sel_f(paddr, `EMS_OFF_RDATA);

    // scan and cycle state
    logic [2:0] sense_q;
    logic [$clog2(`EMS_REF_DIV)-1:0] ref_div_r;
    logic [7:0] scan_cnt_r;
    logic scan_done_r;
    logic found_r;
    logic [4:0] line_r;
    ems_pkg::ems_preset_t cfg_r;
    logic [$clog2(`EMS_HP_DIV+1)-1:0] hp_div_r;
    logic hp_tick;
    logic pco_r;
    ems_pkg::ems_phase_t ph_r;
    logic [4:0] left_r;
    logic [3:0] wait_left_r;
    logic [5:0] rel_r;
    logic odd_r;
    logic busy;
    logic [4:0] total;
    assign busy = ph_r != ems_pkg::PH_IDLE;
    assign hp_tick = hp_div_r == '0;
    assign total = 5'(cfg_r.t1) + 5'(cfg_r.t2) + 5'(cfg_r.t3) + 5'(cfg_r.t4) + 5'(cfg_r.t5) + 5'(cfg_r.t6)
        + 5'(ctrl_r[`EMS_CTRL_HOLD_LSB +: 4]) + 5'(ctrl_r[`EMS_CTRL_WAIT_LSB +: 4]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 32'h0;
            addr_r <= 30'h0;
            wdata_r <= 32'h0;
        end else if (wr_access) begin
            if (sel_f(paddr, `EMS_OFF_CTRL)) begin
                ctrl_r <= {16'h0, pwdata[15:1], 1'b0};
            end
            if (sel_f(paddr, `EMS_OFF_ADDR)) begin
                addr_r <= pwdata[31:2];
            end
            if (sel_f(paddr, `EMS_OFF_WDATA)) begin
                wdata_r <= pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_r <= 1'b0;
        end else if (wr_access && sel_f(paddr, `EMS_OFF_CTRL) && pwdata[`EMS_CTRL_GO] && !busy && scan_done_r) begin
            go_r <= 1'b1;
        end else if (hp_tick && !pco_r && ph_r == ems_pkg::PH_IDLE) begin
            go_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup && !pwrite) begin
                prdata <= 32'h0;
                if (sel_f(paddr, `EMS_OFF_CTRL)) begin
                    prdata <= ctrl_r;
                end
                if (sel_f(paddr, `EMS_OFF_ADDR)) begin
                    prdata <= {addr_r, 2'b00};
                end
                if (sel_f(paddr, `EMS_OFF_WDATA)) begin
                    prdata <= wdata_r;
                end
                if (sel_f(paddr, `EMS_OFF_STATUS)) begin
                    prdata <= {7'h0, ~found_r, cfg_r.late, cfg_r.refresh, 7'h0, line_r, 2'b00, scan_done_r, busy | go_r};
                end
                if (sel_f(paddr, `EMS_OFF_RDATA)) begin
                    prdata <= rdata_r;
                end
            end
        end
    end

    // power-up scan on the input reference period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_q <= 3'b111;
        end else begin
            sense_q <= {sense_q[1:0], config_sense_input};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_div_r <= '0;
            scan_cnt_r <= 8'h0;
            scan_done_r <= 1'b0;
        end else if (!scan_done_r) begin
            ref_div_r <= (ref_div_r == ($clog2(`EMS_REF_DIV))'(`EMS_REF_DIV - 1)) ? '0 : ref_div_r + 1'b1;
            if (ref_div_r == ($clog2(`EMS_REF_DIV))'(`EMS_REF_DIV - 1)) begin
                scan_cnt_r <= scan_cnt_r + 8'h1;
                scan_done_r <= scan_cnt_r == 8'(`EMS_SCAN_WINDOW - 1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            found_r <= 1'b0;
            line_r <= `EMS_DEFAULT_LINE;
            cfg_r <= `EMS_DEFAULT_PRESET;
        end else if (!scan_done_r && !found_r && ref_div_r == '0 && scan_cnt_r[0] == 1'b0
            && scan_cnt_r != 8'h0 && scan_cnt_r <= 8'(2 * `EMS_SCAN_LINES) && !sense_q[2]) begin
            found_r <= 1'b1;
            line_r <= 5'(scan_cnt_r[7:1] - 7'h1);
            cfg_r <= preset_f(5'(scan_cnt_r[7:1] - 7'h1));
        end
    end

    // half-period tick and processor clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hp_div_r <= '0;
            pco_r <= 1'b0;
        end else begin
            hp_div_r <= (hp_div_r == ($bits(hp_div_r))'(`EMS_HP_DIV - 1)) ? '0 : hp_div_r + 1'b1;
            if (hp_tick) begin
                pco_r <= ~pco_r;
            end
        end
    end

    // phase sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_r <= ems_pkg::PH_IDLE;
            left_r <= 5'h0;
            wait_left_r <= 4'h0;
            odd_r <= 1'b0;
        end else if (hp_tick) begin
            if (ph_r != ems_pkg::PH_IDLE && left_r != 5'h0) begin
                left_r <= left_r - 5'h1;
            end else begin
                case (ph_r)
                    ems_pkg::PH_IDLE: begin
                        if (go_r && !pco_r) begin
                            ph_r <= ems_pkg::PH_T1;
                            left_r <= 5'(cfg_r.t1) - 5'h1;
                            odd_r <= total[0];
                            wait_left_r <= ctrl_r[`EMS_CTRL_WAIT_LSB +: 4];
                        end
                    end
                    ems_pkg::PH_T1: begin
                        ph_r <= ems_pkg::PH_T2;
                        left_r <= 5'(cfg_r.t2) - 5'h1;
                    end
                    ems_pkg::PH_T2: begin
                        ph_r <= ems_pkg::PH_T3;
                        left_r <= 5'(cfg_r.t3) - 5'h1;
                    end
                    ems_pkg::PH_T3: begin
                        ph_r <= ems_pkg::PH_T4;
                        left_r <= 5'(cfg_r.t4) - 5'h1;
                    end
                    ems_pkg::PH_T4: begin
                        ph_r <= (wait_left_r != 4'h0) ? ems_pkg::PH_WAIT : ems_pkg::PH_T5;
                        left_r <= (wait_left_r != 4'h0) ? 5'(wait_left_r) - 5'h1 : 5'(cfg_r.t5) - 5'h1;
                    end
                    ems_pkg::PH_WAIT: begin
                        ph_r <= ems_pkg::PH_T5;
                        left_r <= 5'(cfg_r.t5) - 5'h1;
                    end
                    ems_pkg::PH_T5: begin
                        ph_r <= ems_pkg::PH_T6;
                        left_r <= 5'(cfg_r.t6) + 5'(ctrl_r[`EMS_CTRL_HOLD_LSB +: 4]) - 5'h1;
                    end
                    ems_pkg::PH_T6: begin
                        ph_r <= odd_r ? ems_pkg::PH_E : ems_pkg::PH_IDLE;
                    end
                    default: begin
                        ph_r <= ems_pkg::PH_IDLE;
                    end
                endcase
            end
        end
    end

    // half periods since the start of T2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rel_r <= 6'h0;
        end else if (hp_tick) begin
            if (ph_r == ems_pkg::PH_T1) begin
                rel_r <= 6'h0;
            end else if (rel_r != 6'h3f) begin
                rel_r <= rel_r + 6'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0;
        end else if (hp_tick && ph_r == ems_pkg::PH_T5 && left_r == 5'h0 && !ctrl_r[`EMS_CTRL_WRITE]) begin
            rdata_r <= {muxed_addr_data_bus_i, refresh_flag_data1_i, write_flag_data0_i};
        end
    end

    // strobe and bus decode
    logic in_addr;
    logic in_s0;
    logic in_data;
    logic in_wr;
    logic ext_wr;
    logic [31:0] scan_line_high;
    assign in_addr = ph_r == ems_pkg::PH_T1 || ph_r == ems_pkg::PH_T2;
    assign in_s0 = ph_r == ems_pkg::PH_T2 || ph_r == ems_pkg::PH_T3 || ph_r == ems_pkg::PH_T4
        || ph_r == ems_pkg::PH_WAIT || ph_r == ems_pkg::PH_T5;
    assign in_data = ph_r == ems_pkg::PH_T3 || ph_r == ems_pkg::PH_T4 || ph_r == ems_pkg::PH_WAIT
        || ph_r == ems_pkg::PH_T5 || ph_r == ems_pkg::PH_T6 || ph_r == ems_pkg::PH_E;
    assign ext_wr = ctrl_r[`EMS_CTRL_WRITE] & ~ctrl_r[`EMS_CTRL_INTERNAL] & busy;
    assign in_wr = ph_r == ems_pkg::PH_T4 || ph_r == ems_pkg::PH_WAIT || ph_r == ems_pkg::PH_T5
        || (ph_r == ems_pkg::PH_T3 && !cfg_r.late);

    genvar gi;
    generate
        for (gi = 0; gi < `EMS_SCAN_LINES; gi = gi + 1) begin : g_scan
            assign scan_line_high[gi] = scan_done_r || scan_cnt_r < 8'(2 * gi + 1);
        end
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_byte
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    byte_write_strobe_n[gi] <= 1'b1;
                end else begin
                    byte_write_strobe_n[gi] <= ~(ext_wr & in_wr & ctrl_r[`EMS_CTRL_BE_LSB + gi]);
                end
            end
        end
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_delayed
            logic [4:0] d;
            assign d = (gi == 0) ? cfg_r.s2 : (gi == 1) ? cfg_r.s3 : cfg_r.s4;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    delayed_strobe_n[gi] <= 1'b1;
                end else begin
                    delayed_strobe_n[gi] <= ~(d != 5'h0 && in_s0 && rel_r >= 6'(d));
                end
            end
        end
    endgenerate

    logic [31:0] bus_val;
    logic [31:0] bus_oe_n;
    always_comb begin
        bus_val = 32'hffffffff;
        bus_oe_n = 32'h0;
        if (!scan_done_r) begin
            bus_val = scan_line_high;
        end else if (in_addr) begin
            bus_val = {addr_r, 1'b1, ~ctrl_r[`EMS_CTRL_WRITE]};
        end else if (in_data && ctrl_r[`EMS_CTRL_WRITE]) begin
            bus_val = wdata_r;
            for (int b = 0; b < 4; b++) begin
                bus_oe_n[8*b +: 8] = {8{~ctrl_r[`EMS_CTRL_BE_LSB + b]}};
            end
        end else if (in_data) begin
            bus_oe_n = 32'hffffffff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            muxed_addr_data_bus_o <= 30'h3fffffff;
            muxed_addr_data_bus_oe_n <= 30'h0;
            write_flag_data0_o <= 1'b1;
            write_flag_data0_oe_n <= 1'b0;
            refresh_flag_data1_o <= 1'b1;
            refresh_flag_data1_oe_n <= 1'b0;
            address_strobe_n <= 1'b1;
            programmable_width_strobe_n <= 1'b1;
            processor_clock_output <= 1'b0;
        end else begin
            muxed_addr_data_bus_o <= bus_val[31:2];
            muxed_addr_data_bus_oe_n <= bus_oe_n[31:2];
            write_flag_data0_o <= bus_val[0];
            write_flag_data0_oe_n <= bus_oe_n[0];
            refresh_flag_data1_o <= bus_val[1];
            refresh_flag_data1_oe_n <= bus_oe_n[1];
            address_strobe_n <= ~(in_s0 & ~ctrl_r[`EMS_CTRL_INTERNAL]);
            programmable_width_strobe_n <= ~(cfg_r.s1 != 5'h0 && (in_s0 || ph_r == ems_pkg::PH_T6)
                && rel_r < 6'(cfg_r.s1) && !ctrl_r[`EMS_CTRL_INTERNAL]);
            processor_clock_output <= pco_r;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [6:0] cyc_len_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_len_r <= 7'h0;
        end else if (hp_tick) begin
            cyc_len_r <= (ph_r == ems_pkg::PH_IDLE) ? 7'h0 : cyc_len_r + 7'h1;
        end
    end
    sequence s_cycle_end;
        hp_tick && (ph_r == ems_pkg::PH_T6 || ph_r == ems_pkg::PH_E) ##1 ph_r == ems_pkg::PH_IDLE;
    endsequence
    a_even_cycle: assert property (s_cycle_end |-> !cyc_len_r[0]) else $error("odd cycle length");
    a_s0_window: assert property (busy && !in_s0 |=> address_strobe_n) else $error("s0 low outside t2-t5");
    a_s0_falls: assert property (hp_tick && ph_r == ems_pkg::PH_T1 && left_r == 5'h0 && !ctrl_r[2] ##1 1
        |=> !address_strobe_n) else $error("s0 did not fall at t2");
    a_int_no_write: assert property (ctrl_r[`EMS_CTRL_INTERNAL] |=> &byte_write_strobe_n)
        else $error("byte strobe on internal cycle");
    a_late_t3: assert property (ph_r == ems_pkg::PH_T3 && cfg_r.late |=> &byte_write_strobe_n)
        else $error("late write low in t3");
    a_s1_zero: assert property (cfg_r.s1 == 5'h0 |=> programmable_width_strobe_n)
        else $error("zero width strobe went low");
    a_s1_width: assert property (busy && rel_r >= 6'(cfg_r.s1) |=> programmable_width_strobe_n)
        else $error("width strobe too long");
    a_ds_zero: assert property (cfg_r.s2 == 5'h0 |=> delayed_strobe_n[0])
        else $error("zero delay strobe went low");
    a_cfg_held: assert property (scan_done_r |=> $stable(cfg_r)) else $error("config changed after scan");
    a_addr_drive: assert property (in_addr && scan_done_r |=> muxed_addr_data_bus_oe_n == 30'h0)
        else $error("address not driven");
endmodule

// ==== dv/ems_mem_model.sv ====
`timescale 1ns/1ps
module ems_mem_model (
    input wire logic pclk,
    input wire logic [5:0] sense_line,
    input wire logic [31:0] pin_o,
    input wire logic [31:0] pin_oe_n,
    input wire logic [3:0] byte_write_strobe_n,
    output logic [31:0] pin_i,
    output logic config_sense_input,
    output logic [31:0] mem_word
);
    logic [3:0] wr_prev_r;
    // a released line shows the inverse of its last value
    assign pin_i = pin_o ^ pin_oe_n;
    // sense strapped to one scanned line, or held high
    assign config_sense_input = sense_line[5] ? 1'b1 : pin_i[sense_line[4:0]];
    always_ff @(posedge pclk) begin
        wr_prev_r <= byte_write_strobe_n;
        for (int b = 0; b < 4; b++) begin
            if (!wr_prev_r[b] && byte_write_strobe_n[b]) begin
                mem_word[8*b +: 8] <= pin_i[8*b +: 8];
            end
        end
    end
endmodule

// ==== dv/ems_write_strobe_bench.sv ====
`timescale 1ns/1ps
module ems_write_strobe_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, meas = 0, err, as_prev = 1, pco_snap;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, pin_i, mem_word, oe_snap, addr_snap, wd;
    logic pready, pslverr, sense, wf_o, wf_oe_n, rf_o, rf_oe_n, as_n, pw_n, pco;
    logic [29:0] bus_o, bus_oe_n;
    logic [3:0] bws_n;
    logic [2:0] ds_n;
    logic [5:0] sense_line = 6'h20;
    int num_errors = 0, samples_checked = 0, guard, polls, t, w, sp, n_as, n_wr, n_pw, n_tri;
    int n_ds[3];
    // last entry: unlisted line 20 keeps the default, with one extra hold half period
    int cl[5] = '{32, 0, 4, 8, 20};
    int tp[5] = '{4, 1, 1, 1, 4};
    int lt[5] = '{1, 1, 0, 0, 1};
    int rf[5] = '{72, 72, 72, 0, 72};
    int hd[5] = '{0, 0, 0, 0, 1};
    int sv[5][4] = '{'{31, 30, 30, 18}, '{30, 1, 3, 5}, '{3, 1, 2, 3}, '{30, 1, 2, 3}, '{31, 30, 30, 18}};
    initial forever #2 pclk = ~pclk;
    ems_write_strobe u_ems_write_strobe (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .config_sense_input(sense), .muxed_addr_data_bus_i(pin_i[31:2]), .muxed_addr_data_bus_o(bus_o),
        .muxed_addr_data_bus_oe_n(bus_oe_n), .write_flag_data0_i(pin_i[0]), .write_flag_data0_o(wf_o),
        .write_flag_data0_oe_n(wf_oe_n), .refresh_flag_data1_i(pin_i[1]), .refresh_flag_data1_o(rf_o),
        .refresh_flag_data1_oe_n(rf_oe_n), .byte_write_strobe_n(bws_n), .address_strobe_n(as_n),
        .programmable_width_strobe_n(pw_n), .delayed_strobe_n(ds_n), .processor_clock_output(pco));
    ems_mem_model u_ems_mem_model (.pclk(pclk), .sense_line(sense_line), .pin_o({bus_o, rf_o, wf_o}),
        .pin_oe_n({bus_oe_n, rf_oe_n, wf_oe_n}), .byte_write_strobe_n(bws_n), .pin_i(pin_i),
        .config_sense_input(sense), .mem_word(mem_word));
    // low-time counters for the address, byte 0, width and delayed strobes while a cycle is measured
    always @(posedge pclk) begin
        if (meas) begin
            n_as += as_n ? 0 : 1;
            n_wr += bws_n[0] ? 0 : 1;
            n_pw += pw_n ? 0 : 1;
            for (int k = 0; k < 3; k++) n_ds[k] += ds_n[k] ? 0 : 1;
            if (!bws_n[0]) oe_snap <= {bus_oe_n, rf_oe_n, wf_oe_n};
            n_tri += bus_oe_n[6] ? 1 : 0;
            if (as_prev && !as_n) begin
                addr_snap <= {bus_o, rf_o, wf_o};
                pco_snap <= pco;
            end
        end
        as_prev <= as_n;
    end
    task wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        guard = 0;
        do begin
            @(posedge pclk);
            guard++;
        end while (pready !== 1'b1 && guard < 20);
        if (guard >= 20) begin
            num_errors++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_status(int b, logic v);
        polls = 0;
        do begin
            apb(1'b0, 12'h00c, 32'h0);
            polls++;
        end while (rd[b] !== v && polls < 4000);
        if (polls >= 4000) begin
            num_errors++;
            wrap_up();
        end
    endtask
    task run(logic [31:0] ctrl);
        apb(1'b1, 12'h004, 32'h0000_1230);
        apb(1'b1, 12'h008, wd);
        n_tri = 0;
        n_as = 0;
        n_wr = 0;
        n_pw = 0;
        n_ds = '{0, 0, 0};
        meas <= 1'b1;
        apb(1'b1, 12'h000, ctrl | 32'h1);
        wait_status(0, 1'b0);
        repeat (4) @(posedge pclk);
        meas <= 1'b0;
    endtask
    initial begin
        for (int i = 0; i < 5; i++) begin
            wd = 32'ha5c3_3c5a ^ {4{8'(i)}};
            presetn <= 1'b0;
            sense_line <= 6'(cl[i]);
            repeat (2) @(posedge pclk);
            presetn <= 1'b1;
            wait_status(1, 1'b1);
            check("status", rd & 32'h01ff_01f2, ((i == 0) << 24) | (lt[i] << 23) | (rf[i] << 16)
                | ((i == 0 ? 31 : cl[i]) << 4) | 2);
            t = tp[i];
            w = (i == 0) ? 2 : 0;
            sp = 4 * t + w;
            run(32'h0000_0052 | (w << 8) | (hd[i] << 12));
            check("address strobe", n_as, 2 * sp);
            check("address phase", addr_snap, 32'h0000_1232);
            check("clock at t2", pco_snap, t % 2 == 0);
            check("data phase", n_tri, 2 * (sp + hd[i] + (6 * t + w + hd[i]) % 2));
            check("byte strobe", n_wr, 2 * (2 * t + w + (lt[i] ? 0 : t)));
            check("width strobe", n_pw, 2 * (sv[i][0] < sp + t + hd[i] ? sv[i][0] : sp + t + hd[i]));
            for (int k = 0; k < 3; k++) begin
                check("delayed strobe", n_ds[k], 2 * (sv[i][k+1] < sp ? sp - sv[i][k+1] : 0));
            end
            check("written bytes", mem_word & 32'h00ff_00ff, wd & 32'h00ff_00ff);
            check("unwritten tristate", oe_snap, 32'hff00_ff00);
            run(32'h0000_00f6);
            check("on-chip byte strobe", n_wr, 0);
            apb(1'b0, 12'h0f0, 32'h0);
            check("unmapped error", err, 1);
            $display("test %0d done", i);
        end
        wrap_up();
    end
endmodule
